// File: brs_top.sv
// Purpose: board reset generation and processor boot-data selection
// Assumes: all inputs synchronous to clk_i; one clock
// Notes: tristate pins are split into out and enable; bench resolves wire
// Summary of operation
// (RULE1) Processor-facing outputs stay undriven until supply monitor says power good.
// (RULE2) Supply-fail indication from the monitor feeds the reset logic.
// (RULE3) Separate reset outputs: processor group and rest-of-system group.
// (RULE4) Reset switch resets processor and system, no ISA init pulse.
// (RULE5) Board power-good low gives full init, including ISA devices.
// (RULE6) Enabled low fan-sense ORs with switch, driving processor power-good and reset.
// (RULE7) Internal reset buffered onto several system reset outputs.
// (RULE8) Serial ROM output-enable (low) selects the boot-data multiplexer input.
// (RULE9) Mux passes ROM or test-port data to processor boot-data input.
// (RULE10) Processor loads its first code serially from selected source.
// (RULE11) Test-port path stays usable afterwards as software serial line.
// (RULE12) Boot code picks firmware target from two jumper inputs.
// (RULE13) Switch and fan-sense debounced for milliseconds; only stable levels act.
// (RULE14) Processor irq pins carry clock divisor 3..15 during reset.
`default_nettype none
module brs_top
  import brs_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int NUM_SYS_RST = SYS_RST_N,
  parameter logic [3:0] CLK_DIVISOR = 4'h4
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic supply_good_i,
  input wire logic board_pwr_good_i,
  input wire logic reset_switch_n_i,
  input wire logic fan_ok_n_i,
  input wire logic fan_sense_en_i,
  input wire logic srom_oe_n_i,
  input wire logic real_srom_data_i,
  input wire logic test_srom_data_i,
  input wire logic test_srom_tx_i,
  input wire logic [3:0] cpu_irq_src_i,
  input wire logic jumper_a_i,
  input wire logic jumper_b_i,
  output logic cpu_dcok_o,
  output logic cpu_dcok_oe_o,
  output logic cpu_reset_n_o,
  output logic cpu_reset_n_oe_o,
  output logic srom_data_o,
  output logic srom_data_oe_o,
  output logic [3:0] cpu_irq_o,
  output logic cpu_irq_oe_o,
  output logic [NUM_SYS_RST-1:0] sys_reset_n_o,
  output logic isa_init_o,
  output logic test_srom_rx_o,
  output logic boot_target_jumper_a_o,
  output logic boot_target_jumper_b_o
);
  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed
  {
    logic cpu_dcok;
    logic cpu_reset_n;
    logic pins_oe;
    logic srom_data;
    logic [3:0] cpu_irq;
    logic [NUM_SYS_RST-1:0] sys_reset_n;
    logic isa_init;
    logic [4:0] isa_cnt;
    logic test_rx;
    logic jmp_a;
    logic jmp_b;
  } brs_state_t;

  brs_state_t st;
  brs_state_t next_st;
  logic switch_n_stable;
  logic fan_n_stable;
  logic fan_fail;
  logic switch_press;
  logic power_fail;
  logic rst_req;

  // -------------------------------------------------------------
  // debounce of mechanical inputs
  // -------------------------------------------------------------
  brs_debounce #(.CYCLES(DEBOUNCE_CYCLES), .INIT(1'b1)) u_db_switch
  (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_i(reset_switch_n_i),
    .out_o(switch_n_stable)
  ); // [RULE13]

  // starts at the fan-ok level so an enabled sense gives no false reset after sys_rst_i
  brs_debounce #(.CYCLES(DEBOUNCE_CYCLES), .INIT(1'b0)) u_db_fan
  (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_i(fan_ok_n_i),
    .out_o(fan_n_stable)
  ); // [RULE13]

  // -------------------------------------------------------------
  // reset combination
  // -------------------------------------------------------------
  // fan_ok_n high means fan failed; only acts when sensing enabled
  assign fan_fail = fan_sense_en_i & fan_n_stable; // [RULE6]
  assign switch_press = ~switch_n_stable | fan_fail; // [RULE4] [RULE6]
  assign power_fail = ~supply_good_i; // [RULE2]
  assign rst_req = power_fail | ~board_pwr_good_i | switch_press; // [RULE3]

  always_comb
  begin
    next_st = st;
    next_st.pins_oe = supply_good_i; // [RULE1]
    next_st.cpu_dcok = ~rst_req; // [RULE3] [RULE6]
    next_st.cpu_reset_n = ~rst_req; // [RULE3] [RULE6]
    next_st.sys_reset_n = {NUM_SYS_RST{~rst_req}}; // [RULE7]
    // isa init on board power-good or supply loss, never on switch or fan
    if (~board_pwr_good_i | power_fail)
    begin
      next_st.isa_init = 1'b1; // [RULE5]
      next_st.isa_cnt = 5'(ISA_INIT_CYC);
    end
    else if (st.isa_cnt != 5'h00)
    begin
      next_st.isa_cnt = st.isa_cnt - 5'h01;
      next_st.isa_init = 1'b1; // [RULE5]
    end
    else
    begin
      next_st.isa_init = 1'b0; // [RULE4]
    end
    // boot data mux: oe low selects on-board rom
    next_st.srom_data = srom_oe_n_i ? test_srom_data_i : real_srom_data_i; // [RULE8] [RULE9]
    // once rom is idle the test port stays a plain serial line
    next_st.test_rx = test_srom_tx_i; // [RULE11]
    // divisor strapping held while reset asserted, then irq pass-through
    if (rst_req)
    begin
      if (CLK_DIVISOR < DIV_MIN)
      begin
        next_st.cpu_irq = DIV_MIN; // [RULE14]
      end
      else
      begin
        next_st.cpu_irq = CLK_DIVISOR; // [RULE14]
      end
    end
    else
    begin
      next_st.cpu_irq = cpu_irq_src_i;
    end
    next_st.jmp_a = jumper_a_i; // [RULE12]
    next_st.jmp_b = jumper_b_i; // [RULE12]
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st <= '0;
      st.isa_init <= 1'b1;
      st.isa_cnt <= 5'(ISA_INIT_CYC);
    end
    else
    begin
      st <= next_st;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign cpu_dcok_o = st.cpu_dcok;
  assign cpu_dcok_oe_o = st.pins_oe;
  assign cpu_reset_n_o = st.cpu_reset_n;
  assign cpu_reset_n_oe_o = st.pins_oe;
  assign srom_data_o = st.srom_data;
  assign srom_data_oe_o = st.pins_oe;
  assign cpu_irq_o = st.cpu_irq;
  assign cpu_irq_oe_o = st.pins_oe;
  assign sys_reset_n_o = st.sys_reset_n;
  assign isa_init_o = st.isa_init;
  assign test_srom_rx_o = st.test_rx;
  assign boot_target_jumper_a_o = st.jmp_a;
  assign boot_target_jumper_b_o = st.jmp_b;
endmodule
`default_nettype wire

// File: brs_pkg.sv
// Purpose: constants for the board reset and boot-source block
// Assumes: 100 MHz clock
// Notes: debounce time is given in microseconds
`default_nettype none
package brs_pkg;
  localparam int CLK_MHZ = 100;
  localparam int DEBOUNCE_US = 5000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int CNT_W = 20;
  localparam int SYS_RST_N = 4;
  localparam int ISA_INIT_CYC = 16;
  localparam logic [3:0] DIV_MIN = 4'h3;
  localparam logic [3:0] DIV_MAX = 4'hF;
endpackage
`default_nettype wire

// File: brs_debounce.sv
// Purpose: debounce one slow level input
// Assumes: input synchronous to clk_i
// Notes: output changes only after a full stable window
`default_nettype none
module brs_debounce
  import brs_pkg::*;
#(
  parameter int CYCLES = DEBOUNCE_CYC,
  parameter logic INIT = 1'b1
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic in_i,
  output logic out_o
);
  typedef struct packed
  {
    logic [CNT_W-1:0] cnt;
    logic level;
  } brs_db_t;

  brs_db_t st;
  brs_db_t next_st;

  always_comb
  begin
    next_st = st;
    if (in_i == st.level)
    begin
      next_st.cnt = '0;
    end
    else if (st.cnt >= CNT_W'(CYCLES - 1))
    begin
      next_st.cnt = '0;
      next_st.level = in_i;
    end
    else
    begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st <= '{cnt: '0, level: INIT};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign out_o = st.level;
endmodule
`default_nettype wire

// File: brs_props.sv
// Purpose: port properties of brs_top
// Assumes: one clock, sync active-high reset
// Notes: bound to every brs_top
`default_nettype none
module brs_props
#(
  parameter int NUM_SYS_RST = 4
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic supply_good_i,
  input wire logic board_pwr_good_i,
  input wire logic reset_switch_n_i,
  input wire logic srom_oe_n_i,
  input wire logic real_srom_data_i,
  input wire logic test_srom_data_i,
  input wire logic test_srom_tx_i,
  input wire logic cpu_dcok_oe_o,
  input wire logic cpu_reset_n_o,
  input wire logic srom_data_o,
  input wire logic [NUM_SYS_RST-1:0] sys_reset_n_o,
  input wire logic isa_init_o,
  input wire logic test_srom_rx_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_oe;
    !$past(sys_rst_i) |-> cpu_dcok_oe_o == $past(supply_good_i);
  endproperty
  a_oe: assert property (p_oe) else $error("enable not tied to supply");
  property p_fail;
    !supply_good_i |=> isa_init_o;
  endproperty
  a_fail: assert property (p_fail) else $error("supply fail ignored");
  property p_pg;
    $fell(board_pwr_good_i) |=> !cpu_reset_n_o && sys_reset_n_o == '0 && isa_init_o;
  endproperty
  a_pg: assert property (p_pg) else $error("no full init");
  property p_isa;
    $rose(board_pwr_good_i) |=> isa_init_o [*8];
  endproperty
  a_isa: assert property (p_isa) else $error("init pulse short");
  property p_buf;
    !$past(sys_rst_i) |-> (&sys_reset_n_o || !(|sys_reset_n_o));
  endproperty
  a_buf: assert property (p_buf) else $error("system resets differ");
  property p_glitch;
    cpu_reset_n_o && $fell(reset_switch_n_i) && board_pwr_good_i && supply_good_i
      |=> cpu_reset_n_o;
  endproperty
  a_glitch: assert property (p_glitch) else $error("switch not debounced");
  property p_mux;
    !$past(sys_rst_i) |-> srom_data_o ==
      ($past(srom_oe_n_i) ? $past(test_srom_data_i) : $past(real_srom_data_i));
  endproperty
  a_mux: assert property (p_mux) else $error("boot mux wrong");
  property p_rx;
    !$past(sys_rst_i) |-> test_srom_rx_o == $past(test_srom_tx_i);
  endproperty
  a_rx: assert property (p_rx) else $error("serial copy wrong");
endmodule
bind brs_top brs_props #(.NUM_SYS_RST(NUM_SYS_RST)) u_brs_props (.*);
`default_nettype wire

// File: brs_cpu_model.sv
// Purpose: processor side of the boot and reset pins
// Assumes: pins resolved from out and enable
// Notes: no pull on boot line
`default_nettype none
module brs_cpu_model
(
  input wire logic clk_i,
  input wire logic dcok_i,
  input wire logic dcok_oe_i,
  input wire logic boot_i,
  input wire logic boot_oe_i,
  output logic tx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip = 1'b0;
  // undriven pin toggles so a stale value never passes
  always @(posedge clk_i) flip <= ~flip;
  always_ff @(posedge clk_i)
  begin
    tx_o <= (dcok_oe_i && dcok_i) ? (boot_oe_i ? boot_i : flip) : 1'b1;
  end
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench for brs_top
// Assumes: debounce cut to 4 cycles
// Notes: random boot traffic against one-cycle reference
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, sys_rst_i = 1, supply_good_i = 1, board_pwr_good_i = 1;
  logic reset_switch_n_i = 1, fan_ok_n_i = 0, fan_sense_en_i = 0, srom_oe_n_i = 0;
  logic real_srom_data_i = 0, test_srom_data_i = 0, jumper_a_i = 0, jumper_b_i = 0;
  logic [3:0] cpu_irq_src_i = 4'h0, cpu_irq_o, sys_reset_n_o;
  logic test_srom_tx_i, cpu_dcok_o, cpu_dcok_oe_o, cpu_reset_n_o, cpu_reset_n_oe_o;
  logic srom_data_o, srom_data_oe_o, cpu_irq_oe_o, isa_init_o, test_srom_rx_o;
  logic boot_target_jumper_a_o, boot_target_jumper_b_o;
  logic [7:0] rst_vec, exp_q[$];
  logic [3:0] oe_vec;
  int n_errors = 0, checks_done = 0, seed = 32'hE196F9C8;
  brs_top #(.DEBOUNCE_CYCLES(4)) u_brs_top (.*);
  brs_cpu_model u_brs_cpu_model (.clk_i, .dcok_i(cpu_dcok_o), .dcok_oe_i(cpu_dcok_oe_o),
    .boot_i(srom_data_o), .boot_oe_i(srom_data_oe_o), .tx_o(test_srom_tx_i));
  assign rst_vec = {1'b0, cpu_dcok_o, cpu_reset_n_o, sys_reset_n_o, isa_init_o};
  assign oe_vec = {cpu_dcok_oe_o, srom_data_oe_o, cpu_irq_oe_o, cpu_reset_n_oe_o};
  initial forever #5 clk_i = ~clk_i;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic rnd;
    logic [8:0] r;
    logic [7:0] seen;
    r = 9'($random(seed));
    {srom_oe_n_i, real_srom_data_i, test_srom_data_i, jumper_a_i, jumper_b_i} = r[4:0];
    cpu_irq_src_i = r[8:5];
    exp_q.push_back({srom_oe_n_i ? r[2] : r[3], test_srom_tx_i, r[1:0], r[8:5]});
    step(1);
    seen = {srom_data_o, test_srom_rx_o, boot_target_jumper_a_o, boot_target_jumper_b_o, cpu_irq_o};
    chk(seen, exp_q.pop_front());
    chk({4'h0, oe_vec}, 8'h0F);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    step(2);
    sys_rst_i = 0;
    repeat (40) rnd();
    board_pwr_good_i = 0;
    step(1);
    chk(rst_vec, 8'h01);
    step(3);
    chk({4'h0, cpu_irq_o}, 8'h04);
    board_pwr_good_i = 1;
    repeat (16)
    begin
      step(1);
      chk({7'h0, isa_init_o}, 8'h01);
    end
    step(1);
    chk({5'h0, isa_init_o, cpu_reset_n_o, sys_reset_n_o[0]}, 8'h03);
    reset_switch_n_i = 0;
    step(1);
    reset_switch_n_i = 1;
    step(8);
    chk({7'h0, cpu_reset_n_o}, 8'h01);
    for (int k = 0; k < 3; k++)
    begin
      {reset_switch_n_i, fan_ok_n_i, fan_sense_en_i} = (k == 0) ? 3'b000 : {2'b11, k == 2};
      step(10);
      chk(rst_vec, {1'b0, {6{k == 1}}, 1'b0});
      {reset_switch_n_i, fan_ok_n_i} = 2'b10;
      step(10);
      chk({7'h0, cpu_reset_n_o}, 8'h01);
    end
    supply_good_i = 0;
    step(2);
    chk({3'h0, isa_init_o, oe_vec}, 8'h10);
    supply_good_i = 1;
    step(20);
    repeat (10) rnd();
    sys_rst_i = 1;
    step(1);
    chk(rst_vec, 8'h01);
    chk({oe_vec, cpu_irq_o}, 8'h00);
    step(1);
    sys_rst_i = 0;
    repeat (10) rnd();
    stop_test();
  end
  initial
  begin
    #5000;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
